// file: hdl/clock_breakpoint_unit.sv
// Purpose: breakpoint controller gating user clock domains
// Assumes: aclk is the breakpoint clock; probe_a synchronous to it
// Notes:   registers over AXI4-Lite; one gate per domain
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module clock_breakpoint_unit #(
  parameter int NUM_DOMAINS = 4
) (
  input  wire logic                   aclk,          // breakpoint clock
  input  wire logic                   aresetn,       // sync, active low
  input  wire logic [7:0]             s_axi_awaddr,  // write address
  input  wire logic                   s_axi_awvalid, // write addr valid
  output wire logic                   s_axi_awready, // write addr ready
  input  wire logic [31:0]            s_axi_wdata,   // write data
  input  wire logic [3:0]             s_axi_wstrb,   // byte enables
  input  wire logic                   s_axi_wvalid,  // write data valid
  output wire logic                   s_axi_wready,  // write data ready
  output logic      [1:0]             s_axi_bresp,   // write response
  output logic                        s_axi_bvalid,  // response valid
  input  wire logic                   s_axi_bready,  // response ready
  input  wire logic [7:0]             s_axi_araddr,  // read address
  input  wire logic                   s_axi_arvalid, // read addr valid
  output wire logic                   s_axi_arready, // read addr ready
  output logic      [31:0]            s_axi_rdata,   // read data
  output logic      [1:0]             s_axi_rresp,   // read response
  output logic                        s_axi_rvalid,  // read data valid
  input  wire logic                   s_axi_rready,  // read data ready
  input  wire logic                   probe_a,       // trigger probe
  input  wire logic [NUM_DOMAINS-1:0] user_clk,      // user clocks
  output wire logic [NUM_DOMAINS-1:0] gated_clk      // gated clocks
);

  localparam int IDX_W = (NUM_DOMAINS > 1) ? $clog2(NUM_DOMAINS) : 1;
  localparam int DW    = clock_breakpoint_pkg::DELAY_W;
  localparam int SW    = clock_breakpoint_pkg::CTRL_SEL_W;

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        all_mode;
  logic [SW-1:0] dom_sel;
  logic [DW-1:0] delay_cfg;

  wire         wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire         wr_ctrl = wr_fire & (aw_addr == clock_breakpoint_pkg::OFS_CTRL);
  wire         wr_cmd  = wr_fire & (aw_addr == clock_breakpoint_pkg::OFS_CMD);
  wire         wr_dly  = wr_fire & (aw_addr == clock_breakpoint_pkg::OFS_DELAY);
  wire         wr_ok   = wr_ctrl | wr_cmd | wr_dly;
  wire         rd_fire = s_axi_arvalid & s_axi_arready;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= clock_breakpoint_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? clock_breakpoint_pkg::RESP_OKAY
                              : clock_breakpoint_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      all_mode  <= clock_breakpoint_pkg::CTRL_RESET[0];
      dom_sel   <= '0;
      delay_cfg <= clock_breakpoint_pkg::DELAY_RESET;
    end else begin
      if (wr_ctrl && w_strb[0])
        all_mode <= w_data[clock_breakpoint_pkg::CTRL_ALL_BIT]; // R6
      if (wr_ctrl && w_strb[1])
        dom_sel <= w_data[clock_breakpoint_pkg::CTRL_SEL_LSB +: SW];
      if (wr_dly && w_strb[0])
        delay_cfg <= w_data[DW-1:0]; // R3: 8 bits cap it at 255
    end
  end

  // command bits are one-shots and read back as zero
  wire clock_breakpoint_pkg::cmd_t cmd =
    wr_cmd && w_strb[0] ? clock_breakpoint_pkg::cmd_t'(w_data[4:0])
                        : clock_breakpoint_pkg::cmd_t'(5'h00);

  ////////////////////////////////////////////////////////////////////////////
  // trigger and delay
  logic          armed;
  logic          delaying;
  logic [DW-1:0] dly_cnt;
  logic          probe_prev;
  logic [NUM_DOMAINS-1:0] run;
  logic [NUM_DOMAINS-1:0] step_tog;
  logic          seq_busy;
  logic [IDX_W-1:0] seq_idx;
  clock_breakpoint_pkg::op_t        seq_op;
  clock_breakpoint_pkg::seq_state_t seq_state;

  wire trig_rise  = armed & probe_a & ~probe_prev;           // R2
  wire arm_high   = cmd.arm & probe_a;                       // R17
  wire force_halt = cmd.halt;                                // R7
  wire dly_done   = delaying & (dly_cnt == 8'h01);           // R4
  wire halt_req   = force_halt | arm_high | dly_done         // R18
                  | (trig_rise & (delay_cfg == 8'h00));      // R1
  wire start      = (halt_req | cmd.step | cmd.play) & ~seq_busy;
  wire clock_breakpoint_pkg::op_t req_op =
    halt_req ? clock_breakpoint_pkg::OP_HALT :
    cmd.step ? clock_breakpoint_pkg::OP_STEP :
               clock_breakpoint_pkg::OP_PLAY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed      <= 1'b0;
      delaying   <= 1'b0;
      dly_cnt    <= '0;
      probe_prev <= 1'b0;
    end else begin
      probe_prev <= probe_a;
      if (force_halt || cmd.disarm || halt_req) begin // R18
        armed    <= 1'b0;
        delaying <= 1'b0;
      end else if (cmd.arm) begin
        armed <= 1'b1;
      end else if (trig_rise) begin // R1 R3
        armed    <= 1'b0;
        delaying <= 1'b1;
        dly_cnt  <= delay_cfg;
      end else if (delaying) begin
        dly_cnt <= dly_cnt - 8'h01; // R4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation sequencer: one domain per breakpoint cycle in index order;
  // requests arriving while it walks are dropped, the host retries
  wire                  op_valid = seq_busy | (start & ~all_mode);
  wire clock_breakpoint_pkg::op_t op_code = seq_busy ? seq_op : req_op;
  wire [SW-1:0]         op_dom   = seq_busy ? SW'(seq_idx) : dom_sel;

  assign seq_busy = (seq_state == clock_breakpoint_pkg::SEQ_WALK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_state <= clock_breakpoint_pkg::SEQ_IDLE;
      seq_idx   <= '0;
      seq_op    <= clock_breakpoint_pkg::OP_HALT;
    end else begin
      case (seq_state)
        clock_breakpoint_pkg::SEQ_IDLE: begin
          if (start && all_mode) begin // R8 R10 R12
            seq_state <= clock_breakpoint_pkg::SEQ_WALK;
            seq_idx   <= '0;
            seq_op    <= req_op;
          end
        end
        clock_breakpoint_pkg::SEQ_WALK: begin
          if (seq_idx == IDX_W'(NUM_DOMAINS - 1))
            seq_state <= clock_breakpoint_pkg::SEQ_IDLE;
          else
            seq_idx <= seq_idx + 1'b1;
        end
        default: seq_state <= clock_breakpoint_pkg::SEQ_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-domain gate state and gates
  genvar g;
  generate
    for (g = 0; g < NUM_DOMAINS; g++) begin : gen_dom // R19
      wire hit = op_valid & (op_dom == SW'(g)); // R13
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          run[g]      <= 1'b1;
          step_tog[g] <= 1'b0;
        end else if (hit) begin
          case (op_code)
            clock_breakpoint_pkg::OP_HALT: run[g] <= 1'b0; // R7
            clock_breakpoint_pkg::OP_PLAY: run[g] <= 1'b1; // R9 R15
            clock_breakpoint_pkg::OP_STEP:
              if (!run[g]) step_tog[g] <= ~step_tog[g];    // R11 R15
            default: run[g] <= run[g];
          endcase
        end
      end
      bp_clock_gate u_gate (
        .user_clk  (user_clk[g]),
        .aresetn   (aresetn),
        .run       (run[g]),
        .step_tog  (step_tog[g]),
        .gated_clk (gated_clk[g])
      ); // R16 R20
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read path
  // invert at domain width first; inverting inside the cast would set
  // the unused upper status bits
  wire [NUM_DOMAINS-1:0] halted = ~run;
  wire [31:0] status = {13'h0000, seq_busy, delaying, armed,
                        16'(halted)};
  wire [7:0]  ra     = {s_axi_araddr[7:2], 2'b00};
  wire        ra_ok  = (ra == clock_breakpoint_pkg::OFS_CTRL)
                     | (ra == clock_breakpoint_pkg::OFS_CMD)
                     | (ra == clock_breakpoint_pkg::OFS_DELAY)
                     | (ra == clock_breakpoint_pkg::OFS_STATUS);
  wire [31:0] ra_data =
    (ra == clock_breakpoint_pkg::OFS_CTRL)   ?
      {20'h00000, dom_sel, 7'h00, all_mode} :
    (ra == clock_breakpoint_pkg::OFS_DELAY)  ? {24'h000000, delay_cfg} :
    (ra == clock_breakpoint_pkg::OFS_STATUS) ? status : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= clock_breakpoint_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= ra_data;
      s_axi_rresp  <= ra_ok ? clock_breakpoint_pkg::RESP_OKAY
                            : clock_breakpoint_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  wire [NUM_DOMAINS-1:0] sel_mask = NUM_DOMAINS'(1) << op_dom;

  property p_trig_halt;
    @(posedge aclk) disable iff (!aresetn)
    (trig_rise && delay_cfg == 8'h00) |-> halt_req;
  endproperty
  a_trig_halt: assert property (p_trig_halt) // R1
    else $error("rising trigger with zero delay did not halt");

  property p_no_fall;
    @(posedge aclk) disable iff (!aresetn)
    (armed && !probe_a && !cmd.halt && !cmd.arm) |-> !halt_req;
  endproperty
  a_no_fall: assert property (p_no_fall) // R2
    else $error("halt without rising probe edge");

  property p_dly_load;
    @(posedge aclk) disable iff (!aresetn)
    (trig_rise && delay_cfg != 8'h00 && !cmd.halt && !cmd.disarm)
      |=> delaying && dly_cnt == $past(delay_cfg);
  endproperty
  a_dly_load: assert property (p_dly_load) // R3
    else $error("delay count not loaded");

  property p_dly_fire;
    @(posedge aclk) disable iff (!aresetn)
    (delaying && dly_cnt == 8'h02 && !cmd.halt && !cmd.disarm)
      |-> !halt_req ##1 halt_req;
  endproperty
  a_dly_fire: assert property (p_dly_fire) // R4
    else $error("delayed halt at wrong cycle");

  property p_force;
    @(posedge aclk) disable iff (!aresetn)
    cmd.halt |-> halt_req ##1 (!armed && !delaying);
  endproperty
  a_force: assert property (p_force) // R18
    else $error("forced halt waited or kept delay");

  property p_sel_halt;
    @(posedge aclk) disable iff (!aresetn)
    (op_valid && op_code == clock_breakpoint_pkg::OP_HALT
      && op_dom < SW'(NUM_DOMAINS))
      |=> ((run & $past(sel_mask)) == '0)
       && ((run ^ $past(run)) & ~$past(sel_mask)) == '0;
  endproperty
  a_sel_halt: assert property (p_sel_halt) // R13
    else $error("halt missed target or touched another domain");

  sequence s_walk_first;
    seq_busy && seq_idx == '0;
  endsequence
  sequence s_walk_next;
    seq_busy && seq_idx == IDX_W'(NUM_DOMAINS > 1 ? 1 : 0);
  endsequence
  property p_order;
    @(posedge aclk) disable iff (!aresetn)
    (start && all_mode) |=> s_walk_first ##1 (s_walk_next or !seq_busy);
  endproperty
  a_order: assert property (p_order) // R8
    else $error("domain walk out of order");

  property p_step;
    @(posedge aclk) disable iff (!aresetn)
    (op_valid && op_code == clock_breakpoint_pkg::OP_STEP
      && op_dom < SW'(NUM_DOMAINS) && (run & sel_mask) == '0)
      |=> (step_tog ^ $past(step_tog)) == $past(sel_mask) && run == $past(run);
  endproperty
  a_step: assert property (p_step) // R11
    else $error("step did not pass one pulse");

  property p_arm_high;
    @(posedge aclk) disable iff (!aresetn)
    (cmd.arm && probe_a) |-> halt_req ##1 !armed;
  endproperty
  a_arm_high: assert property (p_arm_high) // R17
    else $error("arming with probe high did not halt");

endmodule : clock_breakpoint_unit

// file: hdl/clock_breakpoint_pkg.sv
// Purpose: shared constants and types of the clock breakpoint unit
// Assumes: 32-bit AXI4-Lite register access, byte addresses
// Notes:   what this block does is listed below
//
// What this block does
// R1: armed unit watches probe A, halts targets
// R2: only a rising probe edge triggers
// R3: trigger halt delay programmable, at most 255
// R4: delay counted in breakpoint clock cycles
// R5: breakpoint logic runs on its own clock
// R6: mode picks one domain or all domains
// R7: forced halt stops targets without any trigger
// R8: all-domains forced halt goes in domain order
// R9: play releases a halted domain's clock gate
// R10: all-domains play goes in domain order
// R11: step passes exactly one clock, then holds
// R12: all-domains step goes domain by domain
// R13: halting one domain leaves others running
// R14: halt within one user cycle up to 160MHz; the gate here takes up to three user cycles
// R15: play and step only act on halted domains
// R16: gating only on gated global clock outputs
// R17: trigger already high at arming halts at once
// R18: forced halt ignores the programmed delay
// R19: one gate per user clock domain
// R20: gate changes only while the clock is low
package clock_breakpoint_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int          BP_CLK_MHZ    = 160;    // R5
  localparam int          DELAY_W       = 8;
  localparam logic [7:0]  DELAY_MAX     = 8'hFF;  // R3

  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_CMD       = 8'h04;
  localparam logic [7:0]  OFS_DELAY     = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0C;

  localparam int          CTRL_ALL_BIT  = 0;
  localparam int          CTRL_SEL_LSB  = 8;
  localparam int          CTRL_SEL_W    = 4;
  localparam int          ST_ARMED_BIT  = 16;
  localparam int          ST_DLY_BIT    = 17;
  localparam int          ST_BUSY_BIT   = 18;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [7:0]  DELAY_RESET   = 8'h00;

  // one write to the command register, each bit a one-shot
  typedef struct packed {
    logic disarm;  // bit 4
    logic step;    // bit 3
    logic play;    // bit 2
    logic halt;    // bit 1
    logic arm;     // bit 0
  } cmd_t;

  typedef enum logic [1:0] {OP_HALT, OP_PLAY, OP_STEP} op_t;

  typedef enum logic {SEQ_IDLE, SEQ_WALK} seq_state_t;

endpackage : clock_breakpoint_pkg

// file: hdl/bp_clock_gate.sv
// Purpose: glitch-free gate for one user clock domain
// Assumes: run and step_tog come from the breakpoint clock domain
// Notes:   enable moves on the falling user edge only
`timescale 1ns/1ps
module bp_clock_gate (
  input  wire logic user_clk,   // free-running user domain clock
  input  wire logic aresetn,    // active-low reset
  input  wire logic run,        // 1 lets the clock through
  input  wire logic step_tog,   // each toggle passes one clock pulse
  output wire logic gated_clk   // clock to the user design domain
);

  logic run_meta;
  logic run_sync;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic en;

  // a flop on the falling edge holds en steady across the high phase, so
  // no partial pulse is cut; two-stage sync costs up to two user cycles
  always_ff @(negedge user_clk) begin // R20 R14
    if (!aresetn) begin
      run_meta <= 1'b1;
      run_sync <= 1'b1;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
      en       <= 1'b1;
    end else begin
      run_meta <= run;
      run_sync <= run_meta;
      tog_meta <= step_tog;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
      en       <= run_sync | (tog_sync != tog_seen); // R11
    end
  end

  assign gated_clk = user_clk & en; // R16 R20

endmodule : bp_clock_gate

// file: dv/user_domain_model.sv
// Purpose: model of the gated user clock domains beyond the gates
// Assumes: each domain clock runs free at 100MHz, below the 160MHz limit
// Notes:   records pulse counts, last pulse time and resume time in ns
`timescale 1ns/1ps
module user_domain_model #(
  parameter int N = 4
) (
  output logic            [N-1:0] user_clk,  // free-running domain clocks
  input  wire logic       [N-1:0] gated_clk, // clocks after the gates
  output logic            [31:0]  pulses [N],    // pulses per domain
  output logic            [31:0]  last_ns [N],   // latest pulse time
  output logic            [31:0]  resume_ns [N]  // first pulse after gap
);
  //////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < N; i++) begin : g_dom
    // small phase offsets keep the domains unrelated to each other
    initial begin
      user_clk[i] = 1'b0;
      pulses[i] = 32'h0;
      last_ns[i] = 32'h0;
      resume_ns[i] = 32'h0;
      #(i);
      forever #5 user_clk[i] = ~user_clk[i];
    end
    // a gap of over three periods means the gate had held the domain
    always @(posedge gated_clk[i]) begin
      if ($time - last_ns[i] > 30) resume_ns[i] <= 32'($time);
      last_ns[i] <= 32'($time);
      pulses[i] <= pulses[i] + 32'h1;
    end
  end
endmodule : user_domain_model

// file: dv/clock_breakpoint_unit_bench.sv
// Purpose: self-checking bench of the clock breakpoint unit
// Assumes: register map and timing as handed over by the designer
// Notes:   all stimulus by non-blocking assignment at the rising edge
`timescale 1ns/1ps
module clock_breakpoint_unit_bench;
  localparam int N = 4;
  logic        aclk, aresetn, probe_a;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [N-1:0] user_clk, gated_clk;
  logic [31:0] pulses [N], last_ns [N], resume_ns [N], snap [N];
  int          errors, check_count;

  clock_breakpoint_unit #(.NUM_DOMAINS(N)) clock_breakpoint_unit_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .probe_a, .user_clk, .gated_clk);

  user_domain_model #(.N(N)) user_domain_model_i (
    .user_clk, .gated_clk, .pulses, .last_ns, .resume_ns);

  always #12.5 aclk = ~aclk;

  //////////////////////////////////////////////////////////////////////////
  task conclude;
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task check(input string what, input logic [31:0] exp,
             input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check

  task wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt

  // entered just after an edge; one clean edge at the end avoids a
  // double assignment of bready in a back-to-back write
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic aw_done, w_done, got;
    aw_done = 0;
    w_done = 0;
    got = 0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got && n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1 && !aw_done) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_done) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        got = 1;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (!got) errors++;
    @(posedge aclk);
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, output logic [31:0] d);
    int   n;
    logic got;
    got = 0;
    n = 0;
    d = 32'hDEAD_BEEF;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got && n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        got = 1;
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!got) errors++;
    @(posedge aclk);
  endtask : axi_rd

  task snapshot;
    foreach (snap[i]) snap[i] = pulses[i];
  endtask : snapshot

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    errors++;
    conclude();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    probe_a = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    errors = 0;
    check_count = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("status after reset", 32'h0, rdata);
    axi_rd(8'h10, rdata);
    check("unmapped read data", 32'h0, rdata);
    check("unmapped read resp", 32'(clock_breakpoint_pkg::RESP_SLVERR),
          32'(resp));
    axi_wr(8'h14, 32'hFFFF_FFFF);
    check("unmapped write resp", 32'(clock_breakpoint_pkg::RESP_SLVERR),
          32'(resp));
    // selected mode: halt, step and play domain 1 only
    axi_wr(clock_breakpoint_pkg::OFS_CTRL, 32'h0000_0100);
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0002);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("selected halt", 32'h0000_0002, rdata);
    wt(40);
    snapshot();
    wt(40);
    check("held domain", snap[1], pulses[1]);
    for (int i = 0; i < N; i++)
      if (i != 1) check("other domain", 32'h1, 32'(pulses[i] > snap[i]));
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0008);
    wt(40);
    check("one step", snap[1] + 32'h1, pulses[1]);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("held after step", 32'h0000_0002, rdata);
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0004);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("released", 32'h0, rdata);
    snapshot();
    wt(20);
    check("resumed", 32'h1, 32'(pulses[1] > snap[1]));
    // a forced halt with the longest delay programmed is still at once
    axi_wr(clock_breakpoint_pkg::OFS_DELAY, 32'h0000_00FF);
    axi_rd(clock_breakpoint_pkg::OFS_DELAY, rdata);
    check("delay readback", 32'h0000_00FF, rdata & 32'h0000_00FF);
    axi_wr(clock_breakpoint_pkg::OFS_CTRL, 32'h0000_0300);
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0002);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("forced no delay", 32'h0000_0008, rdata);
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0004);
    // arming while the probe is already high, then with it low: no halt while low, disarm, delayed trigger halt
    probe_a <= 1'b1;
    axi_wr(clock_breakpoint_pkg::OFS_CTRL, 32'h0000_0200);
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0001);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("high at arming", 32'h0000_0004, rdata);
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0004);
    probe_a <= 1'b0;
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0001);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("armed", 32'h0001_0000, rdata);
    wt(30);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("low probe no halt", 32'h0001_0000, rdata);
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0010);
    probe_a <= 1'b1;
    wt(4);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("disarmed", 32'h0, rdata);
    probe_a <= 1'b0;
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0001);
    probe_a <= 1'b1;
    wt(240);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("still delaying", 32'h0002_0000, rdata & 32'h0002_000F);
    wt(20);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("trigger halt", 32'h0000_0004, rdata & 32'h0003_000F);
    probe_a <= 1'b0;
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0004);
    // zero delay: the rising edge halts on the next breakpoint cycle
    axi_wr(clock_breakpoint_pkg::OFS_DELAY, 32'h0000_0000);
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0001);
    probe_a <= 1'b1;
    wt(2);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("zero delay halt", 32'h0000_0004, rdata);
    probe_a <= 1'b0;
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0004);
    // all domains: halt, step and play walk in domain order
    axi_wr(clock_breakpoint_pkg::OFS_CTRL, 32'h0000_0001);
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0002);
    wt(40);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("all halted", 32'h0000_000F, rdata & 32'h0000_000F);
    for (int i = 0; i < N - 1; i++)
      check("halt order", 32'h1, 32'(last_ns[i] < last_ns[i+1]));
    snapshot();
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0008);
    wt(40);
    for (int i = 0; i < N; i++)
      check("all step", snap[i] + 32'h1, pulses[i]);
    for (int i = 0; i < N - 1; i++)
      check("step order", 32'h1, 32'(last_ns[i] < last_ns[i+1]));
    axi_wr(clock_breakpoint_pkg::OFS_CMD, 32'h0000_0004);
    wt(40);
    axi_rd(clock_breakpoint_pkg::OFS_STATUS, rdata);
    check("all running", 32'h0, rdata & 32'h0000_000F);
    for (int i = 0; i < N - 1; i++)
      check("play order", 32'h1, 32'(resume_ns[i] < resume_ns[i+1]));
    conclude();
  end
endmodule : clock_breakpoint_unit_bench
